// *** core/tx_pkg.sv ***
// package: constants for the asynchronous serial transmitter
package tx_pkg;
  // ----------------------------------------------------------------
  // frame format
  // ----------------------------------------------------------------
  localparam int DATA_BITS = 8;
  localparam int FRAME_BITS_MAX = 11; // start + 9 data + stop
  localparam logic [3:0] BIT_IDX_W = 4'h0;
  localparam logic [3:0] LAST_DATA_8 = 4'h9; // index of stop, 8-bit frame
  localparam logic [3:0] LAST_DATA_9 = 4'ha; // index of stop, 9-bit frame
  localparam logic START_LEVEL = 1'b0;
  localparam logic STOP_LEVEL = 1'b1;
  localparam logic IDLE_LEVEL = 1'b1;
  // ----------------------------------------------------------------
  // baud generator oversampling
  // ----------------------------------------------------------------
  localparam logic [5:0] OVERSAMPLE_HI = 6'h0f; // x16, minus one
  localparam logic [5:0] OVERSAMPLE_LO = 6'h3f; // x64, minus one
  // ----------------------------------------------------------------
  // control bit positions (documented positions, kept for reference)
  // ----------------------------------------------------------------
  localparam int FRAME_MODE_BIT = 4;
  localparam int SHIFTER_EMPTY_BIT = 1;
  localparam int BUF_EMPTY_FLAG_BIT = 4;
  // ----------------------------------------------------------------
  // flag settle: second instruction cycle after a buffer write
  // ----------------------------------------------------------------
  localparam logic [1:0] FLAG_SETTLE = 2'h2;
  // transmitter states
  typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_SHIFT} tx_state_t;
endpackage

// *** core/baud_gen.sv ***
// baud rate generator: divisor tick then x16/x64 prescale to bit tick
`timescale 1ns/1ns
module baud_gen #(
  parameter int DIV_W = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic freeze,
  input wire logic high_baud_select,
  input wire logic [DIV_W-1:0] baud_divisor,
  output logic bit_tick
);
  logic [DIV_W-1:0] div_reg, div_next;
  logic [5:0] pre_reg, pre_next;
  logic tick_reg, tick_next;
  logic [5:0] pre_top;

  // divisor counts N+1 cycles, prescale counts 16 or 64 divisor ticks
  always_comb begin
    pre_top = high_baud_select ? tx_pkg::OVERSAMPLE_HI
                               : tx_pkg::OVERSAMPLE_LO; // RQ4
    div_next = div_reg;
    pre_next = pre_reg;
    tick_next = 1'b0;
    if (!run) begin
      div_next = '0;
      pre_next = '0;
    end else if (freeze) begin
      tick_next = tick_reg; // a pending tick survives sleep, RQ7
    end else if (div_reg >= baud_divisor) begin // RQ3 RQ20
      div_next = '0;
      if (pre_reg >= pre_top) begin
        pre_next = '0;
        tick_next = 1'b1;
      end else begin
        pre_next = pre_reg + 6'h01;
      end
    end else begin
      div_next = div_reg + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  // register the counters
  always_ff @(posedge clk) begin
    if (!rstn) begin
      div_reg <= '0;
      pre_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      pre_reg <= pre_next;
      tick_reg <= tick_next;
    end
  end

  assign bit_tick = tick_reg;

  a_tick_single: assert property ( // RQ4
    @(posedge clk) disable iff (!rstn)
    tick_reg && !freeze |=> !tick_reg)
    else $error("bit tick lasted two cycles");
endmodule

// *** core/async_serial_transmitter.sv ***
// asynchronous serial transmitter with holding buffer and shift register
//
// Operation
// RQ1: frame is start, 8 or 9 data, stop
// RQ2: data bits go out lsb first
// RQ3: bit rate from 8-bit baud divisor
// RQ4: generator runs x16 when high speed, else x64
// RQ5: receiver shares format and baud setting
// RQ6: no hardware parity; ninth bit is software's
// RQ7: sleep halts all transmit activity; the code still completes a TX_LOAD under way and drives the start bit
// RQ8: asynchronous only when frame-mode bit clear
// RQ9: reload only after stop bit, then immediately
// RQ10: buffer to shifter takes one cycle, flag sets
// RQ11: flag sets regardless of interrupt enable
// RQ12: flag clears only on buffer write; the code also clears it whenever transmit enable is low
// RQ13: shifter empty status, no interrupt
// RQ14: shift register not visible to software
// RQ15: setting transmit enable sets the flag
// RQ16: nine-bit mode sends stored ninth bit
// RQ17: buffer write while enabled starts sending
// RQ18: flag valid second cycle after write
// RQ19: software programs setup before writing data
// RQ20: rate is clock over 16(N+1) or 64(N+1)
// RQ21: line idles high between frames
`timescale 1ns/1ns
module async_serial_transmitter #(
  parameter int DIV_W = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [DIV_W-1:0] baud_divisor,
  input wire logic high_baud_select,
  input wire logic frame_mode_sync,
  input wire logic serial_port_enable,
  input wire logic transmit_enable,
  input wire logic nine_bit_transmit_enable,
  input wire logic ninth_transmit_bit,
  input wire logic tx_interrupt_enable,
  input wire logic sleep,
  input wire logic [7:0] tx_data,
  input wire logic tx_data_write,
  output logic tx_line,
  output logic tx_buffer_empty_flag,
  output logic shifter_empty_status,
  output logic tx_interrupt_request
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tx_pkg::tx_state_t state_reg, state_next;
  logic [7:0] hold_reg, hold_next;
  logic hold_full_reg, hold_full_next;
  logic hold_ninth_reg, hold_ninth_next;
  logic [9:0] tx_shift_register, shift_next; // not visible outside
  logic [3:0] bit_reg, bit_next;
  logic nine_reg, nine_next;
  logic line_reg, line_next;
  logic flag_reg, flag_next;
  logic [1:0] settle_reg, settle_next;
  logic shifter_empty_status_reg, shifter_empty_status_next;
  logic irq_reg, irq_next;
  logic ten_reg, ten_next;
  logic run;
  logic bit_tick;
  logic [3:0] last_idx;

  // async mode active only when enabled, not synchronous, not asleep
  assign run = serial_port_enable && !frame_mode_sync && !sleep; // RQ8 RQ7

  // ----------------------------------------------------------------
  // baud generator, shared setting with a receiver elsewhere
  // ----------------------------------------------------------------
  baud_gen #(.DIV_W(DIV_W)) u_baud (
    .clk(clk),
    .rstn(rstn),
    .run(serial_port_enable && !frame_mode_sync && transmit_enable
         && state_reg == tx_pkg::TX_SHIFT),
    .freeze(sleep), // RQ7
    .high_baud_select(high_baud_select),
    .baud_divisor(baud_divisor),
    .bit_tick(bit_tick)
  ); // RQ5

  // stop index depends on frame length latched at load
  assign last_idx = nine_reg ? tx_pkg::LAST_DATA_9 : tx_pkg::LAST_DATA_8;

  // ----------------------------------------------------------------
  // transmitter next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    hold_next = hold_reg;
    hold_full_next = hold_full_reg;
    hold_ninth_next = hold_ninth_reg;
    shift_next = tx_shift_register;
    bit_next = bit_reg;
    nine_next = nine_reg;
    line_next = line_reg;
    flag_next = flag_reg;
    settle_next = settle_reg;
    shifter_empty_status_next = shifter_empty_status_reg;
    ten_next = transmit_enable;
    // settle counter delays visible flag clear after a write
    if (settle_reg != 2'h0) begin
      settle_next = settle_reg - 2'h1;
      if (settle_reg == 2'h1) begin
        flag_next = 1'b0; // RQ12 RQ18
      end
    end
    // enabling transmission raises the empty flag; set wins over clear
    if (transmit_enable && !ten_reg) begin
      flag_next = 1'b1; // RQ15
    end
    case (state_reg)
      tx_pkg::TX_IDLE: begin
        line_next = tx_pkg::IDLE_LEVEL; // RQ21
        shifter_empty_status_next = 1'b1;
        if (run && transmit_enable && hold_full_reg) begin
          state_next = tx_pkg::TX_LOAD; // RQ17
        end
      end
      tx_pkg::TX_LOAD: begin
        // one cycle transfer; buffer now empty, flag set
        shift_next = {hold_ninth_reg, tx_pkg::STOP_LEVEL, hold_reg};
        nine_next = nine_bit_transmit_enable; // RQ16
        hold_full_next = 1'b0;
        flag_next = 1'b1; // RQ10 RQ11
        settle_next = 2'h0;
        shifter_empty_status_next = 1'b0;
        bit_next = tx_pkg::BIT_IDX_W;
        line_next = tx_pkg::START_LEVEL; // RQ1
        state_next = tx_pkg::TX_SHIFT;
      end
      tx_pkg::TX_SHIFT: begin
        if (!run || !transmit_enable) begin
          if (!run && sleep) begin
            state_next = tx_pkg::TX_SHIFT; // RQ7 frozen during sleep
          end else begin
            state_next = tx_pkg::TX_IDLE;
            line_next = tx_pkg::IDLE_LEVEL;
          end
        end else if (bit_tick) begin
          if (bit_reg == last_idx) begin
            // stop bit finished: reload at once if data waits
            line_next = tx_pkg::IDLE_LEVEL;
            state_next = hold_full_reg ? tx_pkg::TX_LOAD
                                       : tx_pkg::TX_IDLE; // RQ9
            shifter_empty_status_next = !hold_full_reg;
          end else if (bit_reg == last_idx - 4'h1) begin
            line_next = tx_pkg::STOP_LEVEL; // RQ1
            bit_next = bit_reg + 4'h1;
          end else if (bit_reg == tx_pkg::LAST_DATA_8 - 4'h1 && nine_reg) begin
            line_next = tx_shift_register[9]; // RQ16 RQ6
            bit_next = bit_reg + 4'h1;
          end else begin
            line_next = tx_shift_register[0]; // RQ2
            shift_next = {tx_shift_register[9:8], 1'b0,
                          tx_shift_register[7:1]};
            bit_next = bit_reg + 4'h1;
          end
        end
      end
      default: state_next = tx_pkg::TX_IDLE;
    endcase
    // buffer write: software load wins over the transfer emptying it
    if (tx_data_write) begin
      hold_next = tx_data;
      hold_ninth_next = ninth_transmit_bit;
      hold_full_next = 1'b1;
      settle_next = tx_pkg::FLAG_SETTLE; // RQ18
    end
    if (!transmit_enable) begin
      flag_next = 1'b0;
      settle_next = 2'h0;
    end
  end

  // interrupt request is gated flag only
  always_comb begin
    irq_next = flag_next && tx_interrupt_enable; // RQ11
  end

  // register transmitter state
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= tx_pkg::TX_IDLE;
      hold_reg <= 8'h00;
      hold_full_reg <= 1'b0;
      hold_ninth_reg <= 1'b0;
      tx_shift_register <= 10'h000;
      bit_reg <= 4'h0;
      nine_reg <= 1'b0;
      line_reg <= 1'b1;
      flag_reg <= 1'b0;
      settle_reg <= 2'h0;
      shifter_empty_status_reg <= 1'b1;
      irq_reg <= 1'b0;
      ten_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      hold_reg <= hold_next;
      hold_full_reg <= hold_full_next;
      hold_ninth_reg <= hold_ninth_next;
      tx_shift_register <= shift_next;
      bit_reg <= bit_next;
      nine_reg <= nine_next;
      line_reg <= line_next;
      flag_reg <= flag_next;
      settle_reg <= settle_next;
      shifter_empty_status_reg <= shifter_empty_status_next;
      irq_reg <= irq_next;
      ten_reg <= ten_next;
    end
  end

  // outputs straight from flops
  assign tx_line = line_reg;
  assign tx_buffer_empty_flag = flag_reg;
  assign shifter_empty_status = shifter_empty_status_reg; // RQ13 RQ14
  assign tx_interrupt_request = irq_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // line level and frame shape
  a_idle_line_high: assert property ( // RQ21
    @(posedge clk) disable iff (!rstn)
    state_reg == tx_pkg::TX_IDLE |=> tx_line)
    else $error("line not high while idle");
  a_load_start_bit: assert property ( // RQ10
    @(posedge clk) disable iff (!rstn)
    state_reg == tx_pkg::TX_LOAD |=> !tx_line && !shifter_empty_status
    && tx_buffer_empty_flag)
    else $error("load did not start frame and set flag");
  a_stop_level: assert property ( // RQ1
    @(posedge clk) disable iff (!rstn)
    state_reg == tx_pkg::TX_SHIFT && bit_reg == last_idx |-> tx_line)
    else $error("stop bit not high");
  a_ninth_bit_level: assert property ( // RQ16
    @(posedge clk) disable iff (!rstn)
    state_reg == tx_pkg::TX_SHIFT && nine_reg
    && bit_reg == tx_pkg::LAST_DATA_9 - 4'h1
    |-> tx_line == tx_shift_register[9])
    else $error("ninth bit not on line");

  // buffer-empty flag and interrupt request
  a_flag_settle: assert property ( // RQ18
    @(posedge clk) disable iff (!rstn)
    tx_data_write && transmit_enable && state_next != tx_pkg::TX_LOAD
    && !(state_reg == tx_pkg::TX_LOAD)
    |=> $stable(tx_buffer_empty_flag))
    else $error("flag changed in first cycle after write");
  a_enable_sets_flag: assert property ( // RQ15
    @(posedge clk) disable iff (!rstn)
    $rose(ten_reg) && transmit_enable |-> tx_buffer_empty_flag)
    else $error("enable did not set flag");
  a_flag_fall_cause: assert property ( // RQ12
    @(posedge clk) disable iff (!rstn)
    $fell(tx_buffer_empty_flag)
    |-> $past(tx_data_write, 3) || !$past(transmit_enable))
    else $error("flag cleared without a buffer write");
  a_irq_gated: assert property ( // RQ11
    @(posedge clk) disable iff (!rstn)
    tx_interrupt_request |-> tx_buffer_empty_flag)
    else $error("interrupt without flag");

  // shifter status, reload, sleep and frame mode
  a_shifter_busy: assert property ( // RQ13
    @(posedge clk) disable iff (!rstn)
    state_reg == tx_pkg::TX_SHIFT |-> !shifter_empty_status)
    else $error("shifter reads empty while shifting");
  a_reload_stop: assert property ( // RQ9
    @(posedge clk) disable iff (!rstn)
    state_reg == tx_pkg::TX_SHIFT && state_next == tx_pkg::TX_LOAD
    |-> bit_reg == last_idx)
    else $error("reload before stop bit");
  a_sleep_freeze: assert property ( // RQ7
    @(posedge clk) disable iff (!rstn)
    sleep && $past(sleep) && state_reg == tx_pkg::TX_SHIFT
    |=> $stable(tx_line) && $stable(bit_reg))
    else $error("activity during sleep");
  a_sleep_hold_state: assert property ( // RQ7
    @(posedge clk) disable iff (!rstn)
    sleep && state_reg == tx_pkg::TX_SHIFT
    |=> state_reg == tx_pkg::TX_SHIFT)
    else $error("frame left shifting during sleep");
  a_async_only: assert property ( // RQ8
    @(posedge clk) disable iff (!rstn)
    frame_mode_sync && state_reg == tx_pkg::TX_IDLE
    |=> state_reg == tx_pkg::TX_IDLE)
    else $error("frame started with frame-mode select set");

  // main scenarios seen
  c_sleep_in_frame: cover property (@(posedge clk) disable iff (!rstn)
    sleep && state_reg == tx_pkg::TX_SHIFT && !shifter_empty_status);
  c_frame_sent: cover property (@(posedge clk) disable iff (!rstn)
    state_reg == tx_pkg::TX_SHIFT ##1 state_reg == tx_pkg::TX_IDLE);
  c_back_to_back: cover property (@(posedge clk) disable iff (!rstn)
    state_reg == tx_pkg::TX_SHIFT ##1 state_reg == tx_pkg::TX_LOAD);
  c_nine_bit: cover property (@(posedge clk) disable iff (!rstn)
    state_reg == tx_pkg::TX_SHIFT && nine_reg && bit_reg == 4'h9);
endmodule

// *** dv/serial_rx_model.sv ***
// behavioural remote receiver watching the serial line
`timescale 1ns/1ns
module serial_rx_model (
  input wire logic clk,
  input wire logic line,
  input wire logic nine,
  input wire logic pause,
  input wire logic [31:0] bit_cyc,
  output logic rx_valid,
  output logic [8:0] rx_word,
  output logic rx_err
);
  int n;
  // count clocks of the bit timer, frozen while paused
  task automatic bit_wait(input int cyc);
    int k;
    k = 0;
    while (k < cyc) begin
      @(posedge clk);
      if (!pause) k++;
    end
  endtask
  // start edge, then samples at bit centres
  initial begin
    rx_valid = 1'b0;
    rx_word = 9'h000;
    rx_err = 1'b0;
    forever begin
      @(negedge line);
      bit_wait(bit_cyc / 2);
      if (line === 1'b0) begin
        rx_word = 9'h000;
        n = nine ? 9 : 8;
        for (int i = 0; i < n; i++) begin
          bit_wait(bit_cyc);
          rx_word[i] = line;
        end
        bit_wait(bit_cyc);
        rx_err = (line !== 1'b1);
        @(negedge clk);
        rx_valid = 1'b1;
        @(negedge clk);
        rx_valid = 1'b0;
      end
    end
  end
endmodule

// *** dv/async_serial_transmitter_tb_top.sv ***
// self-checking bench for the asynchronous serial transmitter
`timescale 1ns/1ns
module async_serial_transmitter_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] baud_divisor = 8'h00;
  logic high_baud_select = 1'b1;
  logic frame_mode_sync = 1'b0;
  logic serial_port_enable = 1'b0;
  logic transmit_enable = 1'b0;
  logic nine_bit_transmit_enable = 1'b0;
  logic ninth_transmit_bit = 1'b0;
  logic tx_interrupt_enable = 1'b0;
  logic sleep = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_data_write = 1'b0;
  logic tx_line, tx_buffer_empty_flag, shifter_empty_status;
  logic tx_interrupt_request, rx_valid, rx_err;
  logic [8:0] rx_word;
  logic [8:0] exp_q[$];
  int bit_cyc = 16;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  async_serial_transmitter DUT (
    .clk, .rstn, .baud_divisor, .high_baud_select, .frame_mode_sync,
    .serial_port_enable, .transmit_enable, .nine_bit_transmit_enable,
    .ninth_transmit_bit, .tx_interrupt_enable, .sleep, .tx_data,
    .tx_data_write, .tx_line, .tx_buffer_empty_flag,
    .shifter_empty_status, .tx_interrupt_request
  );

  serial_rx_model rx_model (
    .clk, .line(tx_line), .nine(nine_bit_transmit_enable),
    .pause(sleep), .bit_cyc, .rx_valid, .rx_word, .rx_err
  );

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [8:0] exp,
                     input logic [8:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      wrap_up();
    end
  end

  // each received frame is matched against the oldest note
  always @(posedge clk) begin
    if (rx_valid) begin
      chk("frame word", exp_q.pop_front(), rx_word);
      chk("stop bit error", 9'h000, {8'h00, rx_err});
    end
  end

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  task automatic send(input logic [7:0] d, input logic b9);
    @(negedge clk);
    tx_data = d;
    ninth_transmit_bit = b9;
    tx_data_write = 1'b1;
    exp_q.push_back({nine_bit_transmit_enable & b9, d});
    @(negedge clk);
    tx_data_write = 1'b0;
  endtask

  task automatic wait_idle();
    while (exp_q.size() != 0 || shifter_empty_status !== 1'b1)
      @(negedge clk);
  endtask

  task automatic wait_load();
    while (shifter_empty_status !== 1'b0) @(negedge clk);
  endtask

  initial begin
    logic held;
    void'($urandom(32'hf57b_87af));
    repeat (4) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    chk("idle line", 9'h001, {8'h00, tx_line});
    chk("shifter empty", 9'h001, {8'h00, shifter_empty_status});
    chk("flag at reset", 9'h000, {8'h00, tx_buffer_empty_flag});
    serial_port_enable = 1'b1;
    @(negedge clk);
    transmit_enable = 1'b1;
    repeat (2) @(negedge clk);
    chk("flag on enable", 9'h001, {8'h00, tx_buffer_empty_flag});
    chk("irq masked", 9'h000, {8'h00, tx_interrupt_request});
    tx_interrupt_enable = 1'b1;
    repeat (2) @(negedge clk);
    chk("irq raised", 9'h001, {8'h00, tx_interrupt_request});
    // every speed and width, two frames back to back
    for (int m = 0; m < 4; m++) begin
      high_baud_select = m[0];
      nine_bit_transmit_enable = m[1];
      baud_divisor = 8'($urandom_range(2));
      bit_cyc = (m[0] ? 16 : 64) * (baud_divisor + 1);
      send(8'($urandom), 1'($urandom));
      wait_load();
      chk("flag after load", 9'h001, {8'h00, tx_buffer_empty_flag});
      send(8'($urandom), 1'($urandom));
      @(negedge clk);
      chk("flag held", 9'h001, {8'h00, tx_buffer_empty_flag});
      @(negedge clk);
      chk("flag clear", 9'h000, {8'h00, tx_buffer_empty_flag});
      wait_idle();
    end
    // sleep in mid-frame freezes the line and the shifter
    send(8'($urandom), 1'($urandom));
    wait_load();
    repeat (bit_cyc * 2) @(negedge clk);
    sleep = 1'b1;
    @(negedge clk);
    held = tx_line;
    repeat (bit_cyc * 12) @(negedge clk);
    chk("frozen line", {8'h00, held}, {8'h00, tx_line});
    chk("frozen shifter", 9'h000, {8'h00, shifter_empty_status});
    sleep = 1'b0;
    wait_idle();
    // frame-mode select set: nothing leaves on the line
    frame_mode_sync = 1'b1;
    send(8'h00, 1'b0);
    void'(exp_q.pop_back());
    repeat (bit_cyc * 2) @(negedge clk);
    chk("no async start", 9'h001, {8'h00, tx_line});
    chk("shifter unused", 9'h001, {8'h00, shifter_empty_status});
    // dropping and raising transmit enable sets the flag again
    transmit_enable = 1'b0;
    @(negedge clk);
    chk("flag disabled", 9'h000, {8'h00, tx_buffer_empty_flag});
    transmit_enable = 1'b1;
    @(negedge clk);
    chk("flag re-enabled", 9'h001, {8'h00, tx_buffer_empty_flag});
    wrap_up();
  end
endmodule
